// ---- design/iackn_core.sv ----
// Interrupt acknowledge, priority and nesting controller with APB register slave.
// Assumes the core pulses instr_done at each instruction boundary and stalls while svc_busy is high.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps

module iackn_core
   import iackn_pkg::*;
#(
   parameter logic [15:0] VEC_BASE = 16'h0004,   // Vector of source 0; source i at VEC_BASE + 2*i
   parameter logic [15:0] NMI_VEC  = 16'h0002    // Non-maskable vector address
) (
   input  wire logic        pclk,        // Clock, 20 MHz
   input  wire logic        presetn,     // Asynchronous reset, active low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error on unmapped address
   input  wire logic [15:0] src_req,     // Maskable request pulses
   input  wire logic        nmi_req,     // Non-maskable request pulse
   input  wire logic        instr_done,  // Instruction completes this cycle
   input  wire logic        brk_exec,    // Completing instruction is the soft trap
   input  wire logic        return_from_interrupt_exec,   // Completing instruction is return from interrupt
   input  wire logic        return_from_break_exec,   // Completing instruction is return from break
   input  wire logic        ei_exec,     // Completing instruction sets global accept
   input  wire logic        di_exec,     // Completing instruction clears global accept
   input  wire logic [7:0]  ret_status,  // Status word popped by the return
   output logic             svc_busy,    // Save and vector sequence running
   output logic             push_sw,     // Push status word this cycle
   output logic      [7:0]  push_data,   // Status word to push
   output logic             push_pc,     // Push program counter this cycle
   output logic             pc_load,     // Load PC from vector address this cycle
   output logic      [15:0] vec_addr,    // Vector table address
   output logic      [1:0]  ack_kind,    // Kind of the latest acknowledgement
   output logic             ie_flag,     // Global accept flag
   output logic             isp_flag     // Serving level flag
);

   // ==========================================================================
   // State
   logic [15:0]  pend;
   logic [15:0]  mask;
   logic [15:0]  level;
   logic [7:0]   status_word;
   logic         nmi_pend;
   iackn_state_t state;
   logic [3:0]   cnt;
   iackn_kind_t  kind_stk [STK_DEPTH];
   logic [3:0]   depth;
   logic         stk_ovf;
   logic         bad_ret;
   logic [STK_DEPTH-1:0] nmi_in;

   // ==========================================================================
   // Bus decode
   logic apb_setup;
   logic apb_wr;
   logic hit;

   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite;
   assign hit       = (paddr == OFS_PEND) || (paddr == OFS_MASK) || (paddr == OFS_LEVEL) ||
                      (paddr == OFS_STATUS) || (paddr == OFS_SERVE);
   // Zero wait states keep the core's register accesses short
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~hit;

   // ==========================================================================
   // Selection
   function automatic logic [3:0] pick_first(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : pick_first

   logic        ie;
   logic        serving_level_flag;
   logic        nmi_active;
   logic        ret_now;
   logic [15:0] eligible;
   logic [15:0] acc;
   logic [15:0] acc_hi;
   logic [15:0] grp;
   logic [3:0]  sel;
   logic        at_edge;
   logic        take_soft;
   logic        take_nmi;
   logic        take_mask;
   logic        take_any;

   assign ie         = status_word[SW_IE_BIT];
   assign serving_level_flag        = status_word[SW_ISP_BIT];
   assign nmi_active = |nmi_in;
   // Qualifiers count only at a real boundary; a stalled core reports none
   assign ret_now    = instr_done & (return_from_interrupt_exec | return_from_break_exec);
   assign eligible   = pend & ~mask;
   // Level alone gates nesting; default order only breaks ties below
   assign acc        = eligible & (~level | {16{serving_level_flag}}) & {16{ie & ~nmi_active}};
   assign acc_hi     = acc & ~level;
   assign grp        = (|acc_hi) ? acc_hi : acc;
   assign sel        = pick_first(grp);
   // The return's own boundary never takes, so one more instruction must finish first
   assign at_edge    = (state == S_IDLE) & instr_done & ~ret_now;
   assign take_soft  = (state == S_IDLE) & instr_done & brk_exec;
   assign take_nmi   = at_edge & ~brk_exec & nmi_pend & ~nmi_active;
   assign take_mask  = at_edge & ~brk_exec & ~take_nmi & (|grp);
   assign take_any   = take_soft | take_nmi | take_mask;

   genvar g;
   generate
      for (g = 0; g < STK_DEPTH; g++) begin : g_nmi
         assign nmi_in[g] = (4'(g) < depth) && (kind_stk[g] == K_NMI);
      end
   endgenerate

   // ==========================================================================
   // Request flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= RST_PEND;
      end else begin
         // Hardware set wins over a software write or an acknowledge clear
         pend <= ((apb_wr && paddr == OFS_PEND) ? pwdata[15:0] : pend)
                 & ~(take_mask ? (16'h0001 << sel) : 16'h0000)
                 | src_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend <= 1'b0;
      end else begin
         // Repeated requests collapse into one
         nmi_pend <= (nmi_pend & ~take_nmi) | nmi_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask  <= RST_MASK;
         level <= RST_LEVEL;
      end else begin
         if (apb_wr && paddr == OFS_MASK) begin
            mask <= pwdata[15:0];
         end
         if (apb_wr && paddr == OFS_LEVEL) begin
            level <= pwdata[15:0];
         end
      end
   end

   // ==========================================================================
   // Status word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_word <= RST_STATUS;
      end else if (take_any) begin
         status_word[SW_IE_BIT] <= 1'b0;
         if (take_mask) begin
            status_word[SW_ISP_BIT] <= level[sel];
         end else if (take_nmi) begin
            status_word[SW_ISP_BIT] <= 1'b0;
         end
      end else if (ret_now) begin
         status_word <= ret_status;
      end else if (instr_done && ei_exec) begin
         status_word[SW_IE_BIT] <= 1'b1;
      end else if (instr_done && di_exec) begin
         status_word[SW_IE_BIT] <= 1'b0;
      end else if (apb_wr && paddr == OFS_STATUS) begin
         status_word <= pwdata[7:0];
      end
   end

   // ==========================================================================
   // Save and vector sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         cnt   <= 4'h0;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (take_any) begin
                  state <= S_WAIT;
                  cnt   <= (take_mask && level[sel]) ? WAIT_LO - 4'h1 : WAIT_HI - 4'h1;
               end
            end
            S_WAIT: begin
               if (cnt == 4'h0) begin
                  state <= S_PUSH_SW;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            S_PUSH_SW: begin
               state <= S_PUSH_PC;
            end
            S_PUSH_PC: begin
               state <= S_LOAD;
            end
            S_LOAD: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         push_data <= 8'h00;
         vec_addr  <= 16'h0000;
         ack_kind  <= 2'(K_NONE);
      end else if (take_any) begin
         push_data <= status_word;
         ack_kind  <= take_soft ? 2'(K_SOFT) : take_nmi ? 2'(K_NMI) : 2'(K_MASK);
         if (take_soft) begin
            vec_addr <= SOFT_VEC;
         end else if (take_nmi) begin
            vec_addr <= NMI_VEC;
         end else begin
            vec_addr <= VEC_BASE + {11'h000, sel, 1'b0};
         end
      end
   end

   assign svc_busy = (state != S_IDLE);
   assign push_sw  = (state == S_PUSH_SW);
   assign push_pc  = (state == S_PUSH_PC);
   assign pc_load  = (state == S_LOAD);
   assign ie_flag  = ie;
   assign isp_flag = serving_level_flag;

   // ==========================================================================
   // Handler kind stack: tells which handler a return ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth   <= 4'h0;
         stk_ovf <= 1'b0;
         bad_ret <= 1'b0;
         for (int i = 0; i < STK_DEPTH; i++) begin
            kind_stk[i] <= K_NONE;
         end
      end else if (take_any) begin
         // Beyond the depth the kind is lost; the NMI lock may then end early
         if (depth == 4'(STK_DEPTH)) begin
            stk_ovf <= 1'b1;
         end else begin
            kind_stk[depth[2:0]] <= take_soft ? K_SOFT : take_nmi ? K_NMI : K_MASK;
            depth                <= depth + 4'h1;
         end
      end else if (ret_now && depth != 4'h0) begin
         depth <= depth - 4'h1;
         if (return_from_break_exec != (kind_stk[depth[2:0] - 3'h1] == K_SOFT)) begin
            bad_ret <= 1'b1;
         end
      end else if (apb_wr && paddr == OFS_SERVE) begin
         stk_ovf <= stk_ovf & ~pwdata[5];
         bad_ret <= bad_ret & ~pwdata[6];
      end
   end

   // ==========================================================================
   // Read data, registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         unique case (paddr)
            OFS_PEND:   prdata <= {16'h0000, pend};
            OFS_MASK:   prdata <= {16'h0000, mask};
            OFS_LEVEL:  prdata <= {16'h0000, level};
            OFS_STATUS: prdata <= {24'h000000, status_word};
            OFS_SERVE:  prdata <= {23'h000000, depth, bad_ret, stk_ovf, nmi_active, svc_busy, nmi_pend};
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================================
   // Assertions
   // Cycles from the take edge to the status push: wait count plus one
   localparam int D_HI = LAT_HI_CLK - SEQ_FIXED + 1;
   localparam int D_LO = LAT_LO_CLK - SEQ_FIXED + 1;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [15:0] below_sel;
   assign below_sel = (16'h0001 << sel) - 16'h0001;

   sequence s_save;
      push_sw ##1 push_pc ##1 pc_load;
   endsequence

   property p_elig;
      take_mask |-> eligible[sel] && ie;
   endproperty
   a_elig: assert property (p_elig) else $error("Maskable take without eligibility");

   property p_hi_lat;
      (take_mask && !level[sel]) || take_nmi |-> ##D_HI s_save;
   endproperty
   a_hi_lat: assert property (p_hi_lat) else $error("High level latency wrong");

   property p_lo_lat;
      take_mask && level[sel] |-> ##D_LO s_save;
   endproperty
   a_lo_lat: assert property (p_lo_lat) else $error("Low level latency wrong");

   property p_isp_low;
      take_mask && !serving_level_flag |-> !level[sel];
   endproperty
   a_isp_low: assert property (p_isp_low) else $error("Low request taken in high handler");

   property p_level_first;
      take_mask && (|acc_hi) |-> !level[sel] && ((grp & below_sel) == 16'h0000);
   endproperty
   a_level_first: assert property (p_level_first) else $error("Priority order wrong");

   property p_isp_copy;
      take_mask |=> !ie && (serving_level_flag == $past(level[sel])) ##[11:13] pc_load && (vec_addr[0] == 1'b0);
   endproperty
   a_isp_copy: assert property (p_isp_copy) else $error("Acceptance update wrong");

   property p_pend_clr;
      take_mask && !src_req[sel] |=> !pend[$past(sel)];
   endproperty
   a_pend_clr: assert property (p_pend_clr) else $error("Pending not cleared");

   property p_soft;
      instr_done && brk_exec && !svc_busy |-> (##1 !ie) and (##D_HI s_save ##0 (vec_addr == SOFT_VEC));
   endproperty
   a_soft: assert property (p_soft) else $error("Soft trap not served");

   property p_nmi_lock;
      nmi_active |-> !take_mask && !take_nmi;
   endproperty
   a_nmi_lock: assert property (p_nmi_lock) else $error("Nesting inside NMI handler");

   property p_ret_hold;
      instr_done && ret_now |-> !take_mask && !take_nmi;
   endproperty
   a_ret_hold: assert property (p_ret_hold) else $error("Take at return boundary");

   property p_ret_restore;
      ret_now && !take_any |=> status_word == $past(ret_status);
   endproperty
   a_ret_restore: assert property (p_ret_restore) else $error("Status not restored");

endmodule : iackn_core

// ---- design/iackn_pkg.sv ----
// Constants, types and register map of the interrupt acknowledge and nesting controller.
// Assumes a single 20 MHz clock pclk, an APB slave port and a core that signals instruction boundaries.

package iackn_pkg;

   // ==========================================================================
   // Sizes
   localparam int N_SRC     = 16;
   localparam int STK_DEPTH = 8;

   // ==========================================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_PEND   = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_LEVEL  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_SERVE  = 8'h10;

   // ==========================================================================
   // Reset values
   localparam logic [15:0] RST_PEND   = 16'h0000;
   localparam logic [15:0] RST_MASK   = 16'hFFFF;
   localparam logic [15:0] RST_LEVEL  = 16'hFFFF;
   localparam logic [7:0]  RST_STATUS = 8'h02;

   // ==========================================================================
   // Status word fields
   localparam int SW_IE_BIT  = 7;
   localparam int SW_ISP_BIT = 1;

   // ==========================================================================
   // Vectors and timing (CPU clocks)
   localparam logic [15:0] SOFT_VEC   = 16'h003E;
   localparam int          LAT_HI_CLK = 13;
   localparam int          LAT_LO_CLK = 15;
   localparam int          LAT_MAX_HI = 63;
   localparam int          LAT_MAX_LO = 65;
   localparam int          SEQ_FIXED  = 4;
   localparam logic [3:0]  WAIT_HI    = 4'(LAT_HI_CLK - SEQ_FIXED);
   localparam logic [3:0]  WAIT_LO    = 4'(LAT_LO_CLK - SEQ_FIXED);

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {K_NONE, K_MASK, K_SOFT, K_NMI} iackn_kind_t;
   typedef enum logic [2:0] {S_IDLE, S_WAIT, S_PUSH_SW, S_PUSH_PC, S_LOAD} iackn_state_t;

endpackage : iackn_pkg

// ---- tb/iackn_core_model.sv ----
// Behavioural core on the far side: runs instructions, stalls on svc_busy, keeps a status stack.
// Assumes the bench changes run and op right after a rising edge of pclk.
`timescale 1ns/10ps

module iackn_core_model (
   input  wire logic       pclk,       // Clock
   input  wire logic       presetn,    // Reset, active low
   input  wire logic       run,        // Keep executing instructions
   input  wire logic [2:0] op,         // 1 trap, 2 ret int, 3 ret trap, 4 accept on, 5 accept off
   input  wire logic       svc_busy,   // Save sequence running
   input  wire logic       push_sw,    // Status push pulse
   input  wire logic [7:0] push_data,  // Status word pushed
   input  wire logic       push_pc,    // PC push pulse
   input  wire logic       pc_load,    // Vector load pulse
   output logic            instr_done, // Instruction boundary
   output logic            brk_exec,   // Trap completes
   output logic            return_from_interrupt_exec,  // Return from interrupt completes
   output logic            return_from_break_exec,  // Return from trap completes
   output logic            ei_exec,    // Accept on completes
   output logic            di_exec,    // Accept off completes
   output logic [7:0]      ret_status, // Status word popped
   output logic [7:0]      last_sw,    // Latest pushed status word
   output int              ord_err     // Save order faults seen
);
   logic [7:0] stk [0:15];
   int         sp;
   logic [1:0] ph;

   // Combinational stall: no boundary is ever reported while busy
   assign instr_done = run & ~svc_busy;
   assign brk_exec   = (op == 3'd1);
   assign return_from_interrupt_exec  = (op == 3'd2);
   assign return_from_break_exec  = (op == 3'd3);
   assign ei_exec    = (op == 3'd4);
   assign di_exec    = (op == 3'd5);
   // Empty stack pops a pattern, never a stale word
   assign ret_status = (sp > 0) ? stk[sp-1] : 8'h5A;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp <= 0;
         ph <= 2'b00;
         ord_err <= 0;
         last_sw <= 8'h00;
      end else begin
         if (push_sw) begin
            stk[sp] <= push_data;
            sp <= sp + 1;
            last_sw <= push_data;
         end else if (instr_done && (return_from_interrupt_exec || return_from_break_exec) && sp > 0) begin
            sp <= sp - 1;
         end
         if ((push_pc && !ph[0]) || (pc_load && !ph[1])) begin
            ord_err <= ord_err + 1;
         end
         ph <= {push_pc, push_sw};
      end
   end
endmodule : iackn_core_model

// ---- tb/iackn_core_tb.sv ----
// Self-checking bench for iackn_core: APB register tasks and instruction sequences on the core model.
// Assumes iackn_pkg offsets and the hand-over timing of the acknowledge sequence.
`timescale 1ns/10ps

module iackn_core_tb;
   import iackn_pkg::*;
   localparam logic [15:0] VB = 16'h0004; // Arbitrary vector base
   localparam logic [15:0] NV = 16'h0002; // Arbitrary non-maskable vector
   localparam logic [2:0]  OP_TRAP = 3'd1, OP_RI = 3'd2, OP_RB = 3'd3, OP_ON = 3'd4, OP_OFF = 3'd5;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lasterr;
   logic [7:0]  paddr, push_data, ret_status, last_sw;
   logic [31:0] pwdata, prdata;
   logic [15:0] src_req, vec_addr;
   logic        nmi_req, instr_done, brk_exec, return_from_interrupt_exec, return_from_break_exec, ei_exec, di_exec;
   logic        svc_busy, push_sw, push_pc, pc_load, ie_flag, isp_flag, run;
   logic [1:0]  ack_kind;
   logic [2:0]  op;
   int          fails, n_compared, ord_err;

   iackn_core #(.VEC_BASE(VB), .NMI_VEC(NV)) iackn_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .nmi_req(nmi_req), .instr_done(instr_done), .brk_exec(brk_exec),
      .return_from_interrupt_exec(return_from_interrupt_exec), .return_from_break_exec(return_from_break_exec), .ei_exec(ei_exec), .di_exec(di_exec),
      .ret_status(ret_status), .svc_busy(svc_busy), .push_sw(push_sw), .push_data(push_data),
      .push_pc(push_pc), .pc_load(pc_load), .vec_addr(vec_addr), .ack_kind(ack_kind), .ie_flag(ie_flag),
      .isp_flag(isp_flag));
   iackn_core_model iackn_core_model_inst (.pclk(pclk), .presetn(presetn), .run(run), .op(op),
      .svc_busy(svc_busy), .push_sw(push_sw), .push_data(push_data), .push_pc(push_pc), .pc_load(pc_load),
      .instr_done(instr_done), .brk_exec(brk_exec), .return_from_interrupt_exec(return_from_interrupt_exec), .return_from_break_exec(return_from_break_exec),
      .ei_exec(ei_exec), .di_exec(di_exec), .ret_status(ret_status), .last_sw(last_sw), .ord_err(ord_err));

   always #25 pclk = ~pclk;

   // =========================================================================
   // Tasks
   task automatic final_report;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         fails++;
         final_report;
      end
      q = prdata;
      lasterr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd

   task automatic fl(input logic [1:0] e);
      // Let the flags settle after the edge that updates them
      #1;
      chk(32'({ie_flag, isp_flag}), 32'(e));
   endtask : fl

   task automatic ops(input logic [2:0] o);
      @(posedge pclk);
      op <= o;
      @(posedge pclk);
      op <= 3'd0;
   endtask : ops

   // Pulse requests, run until the vector load, then check vector, kind and, when lat is nonzero, latency
   task automatic take(input logic [15:0] s, input logic m, input logic [2:0] o,
                       input logic [15:0] v, input logic [1:0] k, input int lat);
      int n;
      @(posedge pclk);
      src_req <= s;
      nmi_req <= m;
      op <= o;
      for (n = 1; n < 40; n++) begin
         @(posedge pclk);
         src_req <= 16'h0000;
         nmi_req <= 1'b0;
         op <= 3'd0;
         #1;
         if (pc_load === 1'b1) break;
      end
      if (n == 40) begin
         fails++;
         final_report;
      end
      if (lat > 0) chk(32'(n), 32'(lat));
      chk(32'(vec_addr), 32'(v));
      chk(32'(ack_kind), 32'(k));
   endtask : take

   task automatic none(input logic [15:0] s, input logic m);
      int c;
      c = 0;
      @(posedge pclk);
      src_req <= s;
      nmi_req <= m;
      repeat (20) begin
         @(posedge pclk);
         src_req <= 16'h0000;
         nmi_req <= 1'b0;
         #1;
         if (pc_load === 1'b1) c++;
      end
      chk(32'(c), 32'h0);
   endtask : none

   // =========================================================================
   // Sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, nmi_req, run, lasterr} = 6'h00;
      {paddr, pwdata, src_req, op} = '0;
      fails = 0;
      n_compared = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      run <= 1'b1;
      rd(OFS_PEND, 32'h0);
      rd(OFS_MASK, 32'hFFFF);
      rd(OFS_LEVEL, 32'hFFFF);
      rd(OFS_STATUS, 32'h02);
      fl(2'b01);
      rd(8'h20, 32'h0);
      chk(32'(lasterr), 32'h1);
      wr(OFS_LEVEL, 32'hFFCF);
      ops(OP_ON);
      none(16'h0020, 1'b0);
      rd(OFS_PEND, 32'h20);
      wr(OFS_MASK, 32'h0);
      take(16'h0, 1'b0, 3'd0, VB + 16'd10, 2'd1, 0);
      chk(32'(last_sw), 32'h82);
      fl(2'b00);
      rd(OFS_PEND, 32'h0);
      none(16'h0012, 1'b0);
      ops(OP_ON);
      take(16'h0, 1'b0, 3'd0, VB + 16'd8, 2'd1, 0);
      chk(32'(last_sw), 32'h80);
      ops(OP_ON);
      none(16'h0, 1'b0);
      ops(OP_RI);
      fl(2'b10);
      ops(OP_RI);
      take(16'h0, 1'b0, 3'd0, VB + 16'd2, 2'd1, 0);
      fl(2'b01);
      ops(OP_ON);
      take(16'h0040, 1'b0, 3'd0, VB + 16'd12, 2'd1, 15);
      ops(OP_RI);
      ops(OP_RI);
      take(16'h0012, 1'b0, 3'd0, VB + 16'd8, 2'd1, 13);
      ops(OP_RI);
      take(16'h0, 1'b0, 3'd0, VB + 16'd2, 2'd1, 0);
      ops(OP_RI);
      take(16'h0044, 1'b0, 3'd0, VB + 16'd4, 2'd1, 15);
      ops(OP_RI);
      take(16'h0, 1'b0, 3'd0, VB + 16'd12, 2'd1, 0);
      ops(OP_RI);
      ops(OP_OFF);
      none(16'h0010, 1'b0);
      take(16'h0, 1'b0, OP_TRAP, SOFT_VEC, 2'd2, 0);
      fl(2'b01);
      take(16'h0, 1'b1, 3'd0, NV, 2'd3, 0);
      ops(OP_ON);
      none(16'h0020, 1'b1);
      rd(OFS_SERVE, 32'h45);
      ops(OP_RI);
      take(16'h0, 1'b0, 3'd0, NV, 2'd3, 0);
      ops(OP_RI);
      ops(OP_RB);
      fl(2'b01);
      ops(OP_ON);
      take(16'h0, 1'b0, 3'd0, VB + 16'd8, 2'd1, 0);
      ops(OP_RI);
      take(16'h0, 1'b0, 3'd0, VB + 16'd10, 2'd1, 0);
      ops(OP_RI);
      rd(OFS_SERVE, 32'h0);
      chk(32'(ord_err), 32'h0);
      final_report;
   end
endmodule : iackn_core_tb
